// ===== logic/flash_cfg_defines.svh
// constants for the flash protection and read configuration registers
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

// write instruction opcodes seen on the link
`define OPC_SET_RP_NV     8'h65
`define OPC_SET_RP_V_A    8'hc0
`define OPC_SET_RP_V_B    8'h63
`define OPC_WRITE_FUNC    8'h42

// reset values
`define FUNC_RESET        8'h00
`define READ_PARAM_RESET  8'h00

// function register fields
`define FR_LOCK_MSB       7
`define FR_LOCK_LSB       4
`define FR_ERASE_SUSPENDED_BIT       3
`define FR_PROGRAM_SUSPENDED_BIT       2

// read parameter fields
`define RP_PINSEL_BIT     7
`define RP_DUMMY_MSB      6
`define RP_DUMMY_LSB      3
`define RP_WRAP_BIT       2
`define RP_BURST_MSB      1
`define RP_BURST_LSB      0

// 64 KB block number within the byte address
`define BLK_MSB           19
`define BLK_LSB           16

// default dummy counts when the field is zero
`define DUMMY_FAST_SPI    4'h8
`define DUMMY_FAST_QPI    4'h6
`define DUMMY_DUAL_OUT    4'h8
`define DUMMY_DUAL_IO     4'h4
`define DUMMY_QUAD_OUT    4'h8
`define DUMMY_QUAD_IO     4'h6

// burst lengths in bytes
`define BURST_8           7'h08
`define BURST_16          7'h10
`define BURST_32          7'h20
`define BURST_64          7'h40

`endif

// ===== logic/flash_cfg_pkg.sv
// types shared by the flash configuration register block
package flash_cfg_pkg;

  // read command family that is about to run
  typedef enum logic [2:0] {
    RM_FAST_SPI = 3'h0,
    RM_FAST_QPI = 3'h1,
    RM_DUAL_OUT = 3'h2,
    RM_DUAL_IO  = 3'h3,
    RM_QUAD_OUT = 3'h4,
    RM_QUAD_IO  = 3'h5
  } read_mode_t;

  // array operation asking for permission
  typedef enum logic [1:0] {
    OP_PROGRAM    = 2'h0,
    OP_ERASE      = 2'h1,
    OP_CHIP_ERASE = 2'h2,
    OP_IR_PROGRAM = 2'h3
  } op_kind_t;

  typedef struct packed {
    op_kind_t    kind;
    logic [19:0] addr;
    logic [1:0]  row;
  } op_req_t;

  // one decoded write instruction with its data byte
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
  } link_cmd_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } cfg_state_t;

endpackage

// ===== logic/block_protect_map.sv
// decodes the four block-protect bits into a mask of protected 64 KB blocks
`timescale 1ns/1ps
`default_nettype none

module block_protect_map (
  // protect code
  input  wire logic [3:0]  sel,
  // one bit per block, 1 = protected
  output logic      [15:0] mask
);

  // low codes grow from the top, mirrored high codes from the bottom;
  // the unlisted codes between fail safe to full protection
  always_comb begin
    unique case (sel)
      4'h0:    mask = 16'h0000;
      4'h1:    mask = 16'h8000;
      4'h2:    mask = 16'hc000;
      4'h3:    mask = 16'hf000;
      4'h4:    mask = 16'hff00;
      4'hb:    mask = 16'h00ff;
      4'hc:    mask = 16'h000f;
      4'hd:    mask = 16'h0003;
      4'he:    mask = 16'h0001;
      4'hf:    mask = 16'h0000;
      default: mask = 16'hffff;
    endcase
  end

endmodule

`default_nettype wire

// ===== logic/link_cmd_sync.sv
// carries write instructions from the serial clock into the system clock
`timescale 1ns/1ps
`default_nettype none

module link_cmd_sync (
  // clocks and reset
  input  wire logic                     sys_clk,
  input  wire logic                     link_clk,
  input  wire logic                     rst_n,
  // link side
  input  wire logic                     link_stb,
  input  wire flash_cfg_pkg::link_cmd_t link_cmd,
  output logic                          link_busy,
  // system side
  output logic                          cmd_valid,
  output flash_cfg_pkg::link_cmd_t      cmd
);

  flash_cfg_pkg::link_cmd_t hold_reg, hold_next;
  logic req_tog_reg, req_tog_next;
  logic busy_reg, busy_next;
  logic ack_s1_reg, ack_s2_reg;
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  logic valid_reg, valid_next;
  flash_cfg_pkg::link_cmd_t cmd_reg, cmd_next;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: hold the word and toggle until the ack comes back
  // the held word stays still until then, so it may cross as a bus
  always_comb begin
    hold_next    = hold_reg;
    req_tog_next = req_tog_reg;
    if (link_stb && !busy_reg) begin
      hold_next    = link_cmd;
      req_tog_next = ~req_tog_reg;
    end
    busy_next = (req_tog_next != ack_s2_reg);
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg    <= '0;
      req_tog_reg <= 1'b0;
      busy_reg    <= 1'b0;
      ack_s1_reg  <= 1'b0;
      ack_s2_reg  <= 1'b0;
    end else begin
      hold_reg    <= hold_next;
      req_tog_reg <= req_tog_next;
      busy_reg    <= busy_next;
      ack_s1_reg  <= req_s3_reg;
      ack_s2_reg  <= ack_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: edge of the synced toggle gives a one-cycle valid
  always_comb begin
    valid_next = req_s2_reg ^ req_s3_reg;
    cmd_next   = valid_next ? hold_reg : cmd_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      valid_reg  <= 1'b0;
      cmd_reg    <= '0;
    end else begin
      req_s1_reg <= req_tog_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      valid_reg  <= valid_next;
      cmd_reg    <= cmd_next;
    end
  end

  assign link_busy = busy_reg;
  assign cmd_valid = valid_reg;
  assign cmd       = cmd_reg;

endmodule

`default_nettype wire

// ===== logic/flash_cfg_regs.sv
// protection, function and read parameter registers of the serial flash
`include "flash_cfg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_cfg_regs (
  // clocks and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      NRST,
  input  wire logic                      LINK_CLK,
  // write instructions from the serial side
  input  wire logic                      LINK_CMD_STB,
  input  wire flash_cfg_pkg::link_cmd_t  LINK_CMD,
  output logic                           LINK_BUSY,
  // device state from the core
  input  wire logic [3:0]                PROT_SEL,
  input  wire logic                      QUAD_ENABLE,
  input  wire logic                      QPI_MODE,
  input  wire logic                      PWR_UP_LOAD,
  // array operation permission
  input  wire logic                      OP_REQ,
  input  wire flash_cfg_pkg::op_req_t    OP_INFO,
  output logic                           OP_DONE,
  output logic                           OP_GRANT,
  // suspend and resume
  input  wire logic                      PROG_BUSY,
  input  wire logic                      ERASE_BUSY,
  input  wire logic                      SUSPEND_REQ,
  input  wire logic                      RESUME_REQ,
  // read configuration
  input  wire flash_cfg_pkg::read_mode_t READ_MODE,
  output logic      [3:0]                DUMMY_CYCLES,
  output logic                           WRAP_EN,
  output logic      [6:0]                BURST_BYTES,
  // shared pin function
  output logic                           PIN_AS_HOLD,
  output logic                           PIN_AS_RESET,
  output logic                           PIN_AS_IO3,
  // register contents
  output logic      [7:0]                FUNC_REG,
  output logic      [7:0]                READ_PARAM_REG,
  output logic      [7:0]                READ_PARAM_NV
);

  logic                     cmd_valid;
  flash_cfg_pkg::link_cmd_t cmd;
  logic [15:0]              prot_mask;

  flash_cfg_pkg::cfg_state_t st_reg, st_next;
  logic [7:0] rp_nv_reg, rp_nv_next;
  logic [7:0] rp_vol_reg, rp_vol_next;
  logic [3:0] lock_reg, lock_next;
  logic       program_suspended_reg, program_suspended_next;
  logic       erase_suspended_reg, erase_suspended_next;
  logic       done_reg, done_next;
  logic       grant_reg, grant_next;
  logic       allowed;

  logic [3:0] dummy_reg, dummy_next;
  logic       wrap_reg, wrap_next;
  logic [6:0] burst_reg, burst_next;
  logic       hold_reg, hold_next;
  logic       rstpin_reg, rstpin_next;
  logic       io3_reg, io3_next;

  ////////////////////////////////////////////////////////////////////////////
  // serial-side instructions cross by toggle handshake
  link_cmd_sync u_sync (
    .sys_clk   (SYS_CLK),
    .link_clk  (LINK_CLK),
    .rst_n     (NRST),
    .link_stb  (LINK_CMD_STB),
    .link_cmd  (LINK_CMD),
    .link_busy (LINK_BUSY),
    .cmd_valid (cmd_valid),
    .cmd       (cmd)
  );

  block_protect_map u_map (
    .sel  (PROT_SEL),
    .mask (prot_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // permission for the requested array operation
  always_comb begin
    unique case (OP_INFO.kind)
      flash_cfg_pkg::OP_PROGRAM,
      flash_cfg_pkg::OP_ERASE:
        allowed = !prot_mask[OP_INFO.addr[`BLK_MSB:`BLK_LSB]];
      flash_cfg_pkg::OP_CHIP_ERASE:
        allowed = (PROT_SEL == 4'h0);
      flash_cfg_pkg::OP_IR_PROGRAM:
        allowed = !lock_reg[OP_INFO.row];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state; a suspend in the same cycle as a resume wins
  always_comb begin
    st_next     = st_reg;
    rp_nv_next  = rp_nv_reg;
    rp_vol_next = rp_vol_reg;
    lock_next   = lock_reg;
    program_suspended_next   = program_suspended_reg;
    erase_suspended_next   = erase_suspended_reg;
    done_next   = OP_REQ;
    grant_next  = OP_REQ && allowed;
    if (cmd_valid && cmd.opcode == `OPC_SET_RP_NV) begin
      rp_nv_next = cmd.data;
    end
    // ors in only: a lock bit can never drop, reserved bits discarded
    if (cmd_valid && cmd.opcode == `OPC_WRITE_FUNC) begin
      lock_next = lock_reg | cmd.data[`FR_LOCK_MSB:`FR_LOCK_LSB];
    end
    if (RESUME_REQ) begin
      program_suspended_next = 1'b0;
      erase_suspended_next = 1'b0;
    end
    if (SUSPEND_REQ && PROG_BUSY) begin
      program_suspended_next = 1'b1;
    end
    if (SUSPEND_REQ && ERASE_BUSY) begin
      erase_suspended_next = 1'b1;
    end
    unique case (st_reg)
      flash_cfg_pkg::ST_LOAD: begin
        // working copy follows the persistent one, even a same-cycle write
        rp_vol_next = rp_nv_next;
        st_next     = flash_cfg_pkg::ST_RUN;
      end
      flash_cfg_pkg::ST_RUN: begin
        if (cmd_valid && (cmd.opcode == `OPC_SET_RP_V_A ||
                          cmd.opcode == `OPC_SET_RP_V_B)) begin
          rp_vol_next = cmd.data;
        end
        if (PWR_UP_LOAD) begin
          st_next = flash_cfg_pkg::ST_LOAD;
        end
      end
      default: st_next = flash_cfg_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg     <= flash_cfg_pkg::ST_LOAD;
      rp_nv_reg  <= `READ_PARAM_RESET;
      rp_vol_reg <= `READ_PARAM_RESET;
      lock_reg   <= 4'(`FUNC_RESET >> `FR_LOCK_LSB);
      program_suspended_reg   <= 1'b0;
      erase_suspended_reg   <= 1'b0;
      done_reg   <= 1'b0;
      grant_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      rp_nv_reg  <= rp_nv_next;
      rp_vol_reg <= rp_vol_next;
      lock_reg   <= lock_next;
      program_suspended_reg   <= program_suspended_next;
      erase_suspended_reg   <= erase_suspended_next;
      done_reg   <= done_next;
      grant_reg  <= grant_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded read configuration from the working copy
  always_comb begin
    dummy_next = rp_vol_reg[`RP_DUMMY_MSB:`RP_DUMMY_LSB];
    if (dummy_next == 4'h0) begin
      unique case (READ_MODE)
        flash_cfg_pkg::RM_FAST_SPI: dummy_next = `DUMMY_FAST_SPI;
        flash_cfg_pkg::RM_FAST_QPI: dummy_next = `DUMMY_FAST_QPI;
        flash_cfg_pkg::RM_DUAL_OUT: dummy_next = `DUMMY_DUAL_OUT;
        flash_cfg_pkg::RM_DUAL_IO:  dummy_next = `DUMMY_DUAL_IO;
        flash_cfg_pkg::RM_QUAD_OUT: dummy_next = `DUMMY_QUAD_OUT;
        flash_cfg_pkg::RM_QUAD_IO:  dummy_next = `DUMMY_QUAD_IO;
        default:                    dummy_next = `DUMMY_FAST_SPI;
      endcase
    end
    wrap_next = rp_vol_reg[`RP_WRAP_BIT];
    unique case (rp_vol_reg[`RP_BURST_MSB:`RP_BURST_LSB])
      2'h0: burst_next = `BURST_8;
      2'h1: burst_next = `BURST_16;
      2'h2: burst_next = `BURST_32;
      2'h3: burst_next = `BURST_64;
    endcase
    // zero means whole-array wrap, the burst field is then ignored
    if (!wrap_next) begin
      burst_next = 7'h00;
    end
    io3_next    = QUAD_ENABLE || QPI_MODE;
    hold_next   = !io3_next && !rp_vol_reg[`RP_PINSEL_BIT];
    rstpin_next = !io3_next && rp_vol_reg[`RP_PINSEL_BIT];
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      dummy_reg  <= `DUMMY_FAST_SPI;
      wrap_reg   <= 1'b0;
      burst_reg  <= 7'h00;
      hold_reg   <= 1'b1;
      rstpin_reg <= 1'b0;
      io3_reg    <= 1'b0;
    end else begin
      dummy_reg  <= dummy_next;
      wrap_reg   <= wrap_next;
      burst_reg  <= burst_next;
      hold_reg   <= hold_next;
      rstpin_reg <= rstpin_next;
      io3_reg    <= io3_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign OP_DONE        = done_reg;
  assign OP_GRANT       = grant_reg;
  assign DUMMY_CYCLES   = dummy_reg;
  assign WRAP_EN        = wrap_reg;
  assign BURST_BYTES    = burst_reg;
  assign PIN_AS_HOLD    = hold_reg;
  assign PIN_AS_RESET   = rstpin_reg;
  assign PIN_AS_IO3     = io3_reg;
  assign FUNC_REG       = {lock_reg, erase_suspended_reg, program_suspended_reg, 2'h0};
  assign READ_PARAM_REG = rp_vol_reg;
  assign READ_PARAM_NV  = rp_nv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  chk_chip_erase_gate: assert property (
    OP_REQ && OP_INFO.kind == flash_cfg_pkg::OP_CHIP_ERASE &&
    PROT_SEL != 4'h0 |=> OP_DONE && !OP_GRANT)
    else $error("chip erase granted with protection set");

  chk_block_inhibit: assert property (
    OP_REQ && OP_INFO.kind == flash_cfg_pkg::OP_PROGRAM &&
    prot_mask[OP_INFO.addr[`BLK_MSB:`BLK_LSB]] |=> !OP_GRANT)
    else $error("program granted inside protected block");

  chk_mid_codes_all: assert property (
    PROT_SEL inside {4'h8, 4'h9, 4'ha} |-> prot_mask == 16'hffff)
    else $error("intermediate code did not protect all");

  chk_top_block: assert property (
    PROT_SEL == 4'h1 |-> prot_mask == 16'h8000)
    else $error("code one must protect only block 15");

  chk_program_suspended_set: assert property (
    SUSPEND_REQ && PROG_BUSY |=> FUNC_REG[`FR_PROGRAM_SUSPENDED_BIT] [*1]
    ##1 (FUNC_REG[`FR_PROGRAM_SUSPENDED_BIT] || $past(RESUME_REQ)))
    else $error("program suspend flag not held");

  chk_erase_suspended_clear: assert property (
    RESUME_REQ && !SUSPEND_REQ |=> !FUNC_REG[`FR_ERASE_SUSPENDED_BIT])
    else $error("erase suspend flag not cleared on resume");

  chk_lock_otp: assert property (
    ##1 ((lock_reg & $past(lock_reg)) == $past(lock_reg)))
    else $error("lock bit returned to zero");

  chk_lock_deny: assert property (
    OP_REQ && OP_INFO.kind == flash_cfg_pkg::OP_IR_PROGRAM &&
    lock_reg[OP_INFO.row] |=> OP_DONE && !OP_GRANT)
    else $error("locked info row program granted");

  chk_nv_only: assert property (
    cmd_valid && cmd.opcode == `OPC_SET_RP_NV &&
    st_reg == flash_cfg_pkg::ST_RUN
    |=> rp_nv_reg == $past(cmd.data) && $stable(rp_vol_reg))
    else $error("persistent write touched working copy");

  chk_load_copy: assert property (
    st_reg == flash_cfg_pkg::ST_LOAD && !cmd_valid
    |=> rp_vol_reg == $past(rp_nv_reg)
    ##1 (READ_PARAM_REG == rp_nv_reg || $past(cmd_valid)))
    else $error("power-up load did not copy parameters");

  chk_dummy_default: assert property (
    rp_vol_reg[`RP_DUMMY_MSB:`RP_DUMMY_LSB] == 4'h0 &&
    READ_MODE == flash_cfg_pkg::RM_DUAL_IO |=> DUMMY_CYCLES == 4'h4)
    else $error("dual io default dummy count wrong");

  chk_reserved_zero: assert property (
    FUNC_REG[1:0] == 2'h0)
    else $error("reserved function bits not zero");

endmodule

`default_nettype wire

// ===== sim/link_host.sv
// far-side host model: issues register write instructions on the link
`timescale 1ns/1ps
`default_nettype none

module link_host (
  // link clock and reset
  output logic                     link_clk,
  input  wire logic                rst_n,
  // write instruction channel
  output logic                     link_stb,
  output flash_cfg_pkg::link_cmd_t link_cmd,
  input  wire logic                link_busy
);
  logic run;

  // serial clock runs in reset and during a write, else it stands low
  initial begin
    link_clk = 1'b0;
    link_stb = 1'b0;
    link_cmd = 16'h0000;
    run = 1'b0;
    #3;
    forever begin
      #16;
      link_clk = (run || !rst_n) ? ~link_clk : 1'b0;
    end
  end

  // one write: wait idle, pulse the strobe, wait for the ack to come back
  task automatic send(input logic [7:0] opc, input logic [7:0] dat);
    int n;
    run = 1'b1;
    for (n = 0; n < 64 && link_busy !== 1'b0; n++) @(negedge link_clk);
    @(negedge link_clk);
    link_cmd = {opc, dat};
    link_stb = 1'b1;
    @(negedge link_clk);
    link_stb = 1'b0;
    link_cmd = ~{opc, dat}; // released word must not look still valid
    for (n = 0; n < 64 && link_busy !== 1'b0; n++) @(negedge link_clk);
    run = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the flash configuration register block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end \
end

module tb;
  logic                      sys_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      link_clk, link_stb, link_busy;
  flash_cfg_pkg::link_cmd_t  link_cmd;
  logic [3:0]                prot_sel = 4'h0;
  logic                      quad_en = 1'b0, qpi = 1'b0, pwr_load = 1'b0;
  logic                      op_req = 1'b0, op_done, op_grant;
  flash_cfg_pkg::op_req_t    op_info = '0;
  logic                      prog_busy = 1'b0, erase_busy = 1'b0;
  logic                      susp = 1'b0, resume = 1'b0;
  flash_cfg_pkg::read_mode_t rd_mode = flash_cfg_pkg::RM_FAST_SPI;
  logic [3:0]                dummy;
  logic [6:0]                burst;
  logic                      wrap, p_hold, p_rst, p_io3;
  logic [7:0]                func, rp, rp_nv, d;
  int                        fails = 0, checks = 0, cyc = 0, c, b, i;
  logic [31:0]               xs = 32'h5c;
  // reference state
  logic [7:0]                m_rp = 8'h00, m_nv = 8'h00;
  logic [3:0]                m_lk = 4'h0;
  logic [3:0]                dflt [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6};

  // system clock
  always #5 sys_clk = ~sys_clk;

  link_host i_host (.link_clk(link_clk), .rst_n(rst_n), .link_stb(link_stb),
    .link_cmd(link_cmd), .link_busy(link_busy));

  flash_cfg_regs i_dut (.SYS_CLK(sys_clk), .NRST(rst_n), .LINK_CLK(link_clk),
    .LINK_CMD_STB(link_stb), .LINK_CMD(link_cmd), .LINK_BUSY(link_busy),
    .PROT_SEL(prot_sel), .QUAD_ENABLE(quad_en), .QPI_MODE(qpi),
    .PWR_UP_LOAD(pwr_load), .OP_REQ(op_req), .OP_INFO(op_info),
    .OP_DONE(op_done), .OP_GRANT(op_grant), .PROG_BUSY(prog_busy),
    .ERASE_BUSY(erase_busy), .SUSPEND_REQ(susp), .RESUME_REQ(resume),
    .READ_MODE(rd_mode), .DUMMY_CYCLES(dummy), .WRAP_EN(wrap),
    .BURST_BYTES(burst), .PIN_AS_HOLD(p_hold), .PIN_AS_RESET(p_rst),
    .PIN_AS_IO3(p_io3), .FUNC_REG(func), .READ_PARAM_REG(rp),
    .READ_PARAM_NV(rp_nv));

  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction

  // reference protection map of the 16-block array
  function automatic logic prot(input int code, input int blk);
    if (code == 0 || code == 15) return 1'b0;
    if (code >= 5 && code <= 10) return 1'b1;
    if (code < 5) return blk >= 16 - (1 << (code - 1));
    return blk < (1 << (14 - code));
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one permission request; answer is due exactly one cycle later
  task automatic op(input int k, input int blk, input int row, input logic g);
    logic [31:0] r;
    r = rnd();
    tick(1);
    op_req = 1'b1;
    op_info = {flash_cfg_pkg::op_kind_t'(k), blk[3:0], r[15:0], row[1:0]};
    tick(1);
    `CHK("op", {1'b1, g}, {op_done, op_grant})
    op_req = 1'b0;
  endtask

  // every read mode and pin mode against the working copy
  task automatic chk_cfg();
    int m, q;
    for (q = 0; q < 4; q++) begin
      for (m = 0; m < 6; m++) begin
        rd_mode = flash_cfg_pkg::read_mode_t'(m);
        {quad_en, qpi} = q[1:0];
        tick(2);
        `CHK("dummy", m_rp[6:3] != 0 ? m_rp[6:3] : dflt[m], dummy)
        `CHK("wrap", m_rp[2], wrap)
        `CHK("burst", m_rp[2] ? 7'h08 << m_rp[1:0] : 7'h00, burst)
        `CHK("pin", {q == 0 && !m_rp[7], q == 0 && m_rp[7], q != 0},
          {p_hold, p_rst, p_io3})
      end
    end
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // main sequence
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(2);
    `CHK("func rst", 8'h00, func)
    `CHK("rp rst", 8'h00, rp)
    `CHK("nv rst", 8'h00, rp_nv)
    // protection codes across every block, chip erase per code
    for (c = 0; c < 16; c++) begin
      prot_sel = c[3:0];
      for (b = 0; b < 16; b++) op(b % 2, b, 0, !prot(c, b));
      op(2, 0, 0, c == 0);
    end
    prot_sel = 4'h0;
    // lock bits only ever set; reserved bits ignored
    for (i = 0; i < 3; i++) begin
      d = 8'(rnd());
      d[3:0] = 4'hf;
      if (i == 2) d = 8'h0f;
      i_host.send(8'h42, d);
      m_lk = m_lk | d[7:4];
      tick(3);
      `CHK("func", {m_lk, 4'h0}, func)
    end
    for (i = 0; i < 4; i++) op(3, i, i, !m_lk[i]);
    // suspend during program, then during erase
    for (i = 0; i < 2; i++) begin
      prog_busy = i == 0;
      erase_busy = i == 1;
      susp = 1'b1;
      tick(1);
      susp = 1'b0;
      tick(1);
      `CHK("susp", i == 0 ? 2'b01 : 2'b10, func[3:2])
      resume = 1'b1;
      tick(1);
      resume = 1'b0;
      tick(1);
      `CHK("resume", 2'b00, func[3:2])
    end
    // suspend and resume in one cycle: the set wins
    erase_busy = 1'b0;
    prog_busy = 1'b1;
    susp = 1'b1;
    resume = 1'b1;
    tick(1);
    susp = 1'b0;
    resume = 1'b0;
    tick(1);
    `CHK("susp win", 2'b01, func[3:2])
    resume = 1'b1;
    tick(1);
    resume = 1'b0;
    tick(1);
    `CHK("resume win", 2'b00, func[3:2])
    prog_busy = 1'b0;
    erase_busy = 1'b0;
    // persistent and working copies written separately
    for (i = 0; i < 6; i++) begin
      d = 8'(rnd());
      case (i % 3)
        0: begin
          i_host.send(8'h65, d);
          m_nv = d;
        end
        1: begin
          i_host.send(8'hc0, d);
          m_rp = d;
        end
        default: begin
          i_host.send(8'h63, d);
          m_rp = d;
        end
      endcase
      tick(3);
      `CHK("rp pair", {m_nv, m_rp}, {rp_nv, rp})
      chk_cfg();
    end
    // power-up reload of the working copy
    pwr_load = 1'b1;
    tick(1);
    pwr_load = 1'b0;
    tick(3);
    m_rp = m_nv;
    `CHK("reload", m_nv, rp)
    chk_cfg();
    summarize();
  end
endmodule

`default_nettype wire
